// file: cgsc_pkg.sv
// package for the ccd gain steering and clamp control block
// constants shared by the design and its verification
package cgsc_pkg;

  // register addresses on the serial write port
  localparam logic [7:0] REG_OPER_MODE   = 8'h05;
  localparam logic [7:0] REG_STEER_SEL   = 8'h06;
  localparam logic [7:0] REG_CLAMP_LEVEL = 8'h07;
  localparam logic [7:0] REG_VGA_GAIN    = 8'h08;
  localparam logic [7:0] REG_CLAMP_DIV   = 8'h09;
  localparam logic [7:0] REG_INT_CFG     = 8'h0a;
  localparam logic [7:0] REG_PIX_GAIN0   = 8'h0c;

  // field widths and positions
  localparam int PIX_GAIN_W    = 6;
  localparam int VGA_GAIN_W    = 10;
  localparam int CLAMP_LVL_W   = 8;
  localparam int STEER_W       = 3;
  localparam int OPER_CLAMP_OFF_BIT = 2;
  localparam int INT_MODE_BIT  = 0;
  localparam int ADC_W         = 12;
  localparam int CORR_W        = 10;

  // reset values
  localparam logic [STEER_W-1:0]     STEER_RST  = 3'h0;
  localparam logic [7:0]             OPER_RST   = 8'h00;
  localparam logic [CLAMP_LVL_W-1:0] CLAMP_RST  = 8'h00;
  localparam logic [VGA_GAIN_W-1:0]  VGA_RST    = 10'h000;
  localparam logic [PIX_GAIN_W-1:0]  PGAIN_RST  = 6'h00;
  localparam logic [7:0]             CDIV_RST   = 8'h00;

  // vga law boundary: region 0 is codes 0..511, region 1 is 512..1023
  localparam logic [VGA_GAIN_W-1:0] VGA_REGION_EDGE = 10'h200;

  // h-counter resets on the sixth clock rising edge after horizontal sync falls
  localparam int HSYNC_RESET_EDGE = 6;
  // the synchroniser and edge detect use up the first three edges, so the delay count stops early
  localparam logic [2:0] HSYNC_DLY_LAST = 3'h2;

  // internal pulse timing in pixels from h-counter reset
  localparam logic [11:0] CLAMP_START  = 12'h004;
  localparam int          CLAMP_MIN_PIX = 20;
  localparam logic [11:0] CLAMP_LEN    = 12'h014;
  localparam logic [11:0] DUMMY_START  = 12'h020;
  localparam int          DUMMY_MIN_PIX = 4;
  localparam logic [11:0] DUMMY_LEN    = 12'h004;
  localparam logic [11:0] BLANK_START  = 12'h000;
  localparam logic [11:0] BLANK_LEN    = 12'h040;

  // steering modes
  typedef enum logic [2:0] {
    STEER_MOSAIC    = 3'b000,
    STEER_VSYNC_SEL = 3'b001,
    STEER_MOSAIC_IL = 3'b010,
    STEER_THREE     = 3'b011,
    STEER_FOUR_I    = 3'b100,
    STEER_FOUR_II   = 3'b101,
    STEER_FIXED     = 3'b110
  } cgsc_steer_t;

endpackage

// file: cgsc_ctrl.sv
// top module of the ccd gain steering and clamp control block
// assumes sync and pulse inputs come from another clock domain (pins); the register write port is used unsynchronised
`timescale 1ns/100ps
// Behaviour
// - four pixel gain registers, one selected per pixel by steering
// - seven steering modes chosen by steering select register at 0x06
// - mosaic mode: lines alternate 0/1 then 2/3, repeating every two lines
// - vsync selected mode: even field uses 0/1, odd field uses 2/3
// - steering sequence is synchronised to external vertical and horizontal sync
// - each pixel gain is a 6-bit code, 64 steps
// - variable gain takes a 10-bit code from the serial port
// - gain code splits into regions 0..511 and 512..1023
// - clamp reference level is an 8-bit programmable value
// - during black interval compare output to reference, filter, drive correction
// - clamp loop updates once per line or less often by divider
// - operating mode bit 2 disables the clamp loop
// - disabled loop still applies clamp level as fixed offset
// - black clamp pulse over black pixels, at least 20 pixels recommended
// - internal mode generates clamp and blank pulses from sync only
// - vsync fall resets to 0/1 line; hsync fall toggles line pattern
// - h-counter resets six clock edges after hsync falls; steering aligned there
module cgsc_ctrl
  import cgsc_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // serial register write port, already deserialised
  input  wire logic                   reg_wr_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [11:0]            reg_data_i,
  // sync and external pulses
  input  wire logic                   vertical_sync_i,
  input  wire logic                   horizontal_sync_i,
  input  wire logic                   black_clamp_pulse_i,
  input  wire logic                   dummy_clamp_pulse_i,
  input  wire logic                   pre_blank_pulse_i,
  input  wire logic                   horiz_blank_pulse_i,
  // converter output
  input  wire logic [ADC_W-1:0]       adc_data_i,
  // gain and clamp outputs
  output logic [PIX_GAIN_W-1:0]       pixel_gain_amp_o,
  output logic [1:0]                  gain_sel_o,
  output logic [VGA_GAIN_W-1:0]       vga_gain_o,
  output logic                        vga_region_o,
  output logic [CORR_W-1:0]           clamp_dac_o,
  output logic                        field_odd_o,
  output logic [STEER_W-1:0]          steer_mode_o,
  output logic                        black_clamp_pulse_o,
  output logic                        dummy_clamp_pulse_o,
  output logic                        pre_blank_pulse_o,
  output logic                        horiz_blank_pulse_o
);

  // synchronisers for pin inputs
  logic [1:0] vs_sync;
  logic [1:0] hs_sync;
  logic [1:0] clp_sync;
  logic [1:0] dm_sync;
  logic [1:0] pb_sync;
  logic [1:0] hb_sync;
  logic       vs_prev;
  logic       hs_prev;
  logic       vs_fall;
  logic       hs_fall;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      vs_sync  <= 2'h3;
      hs_sync  <= 2'h3;
      clp_sync <= 2'h0;
      dm_sync  <= 2'h0;
      pb_sync  <= 2'h0;
      hb_sync  <= 2'h0;
      vs_prev  <= 1'b1;
      hs_prev  <= 1'b1;
    end else begin
      vs_sync  <= {vs_sync[0], vertical_sync_i};
      hs_sync  <= {hs_sync[0], horizontal_sync_i};
      clp_sync <= {clp_sync[0], black_clamp_pulse_i};
      dm_sync  <= {dm_sync[0], dummy_clamp_pulse_i};
      pb_sync  <= {pb_sync[0], pre_blank_pulse_i};
      hb_sync  <= {hb_sync[0], horiz_blank_pulse_i};
      vs_prev  <= vs_sync[1];
      hs_prev  <= hs_sync[1];
    end
  end

  assign vs_fall = vs_prev & ~vs_sync[1];
  assign hs_fall = hs_prev & ~hs_sync[1];

  // registers written by the serial port; only steering, vga and pixel gain values are shadows copied at sync falls
  logic [PIX_GAIN_W-1:0]  pg_shadow [4];
  logic [PIX_GAIN_W-1:0]  pg_live   [4];
  logic [STEER_W-1:0]     steer_shadow;
  logic [STEER_W-1:0]     color_steer_select;
  logic [7:0]             operating_mode_reg;
  logic [CLAMP_LVL_W-1:0] clamp_level;
  logic [VGA_GAIN_W-1:0]  vga_shadow;
  logic [7:0]             clamp_div;
  logic                   internal_mode;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      steer_shadow       <= STEER_RST;
      operating_mode_reg <= OPER_RST;
      clamp_level        <= CLAMP_RST;
      vga_shadow         <= VGA_RST;
      clamp_div          <= CDIV_RST;
      internal_mode      <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == REG_STEER_SEL) begin
        steer_shadow <= reg_data_i[STEER_W-1:0];
      end else if (reg_addr_i == REG_OPER_MODE) begin
        operating_mode_reg <= reg_data_i[7:0];
      end else if (reg_addr_i == REG_CLAMP_LEVEL) begin
        clamp_level <= reg_data_i[CLAMP_LVL_W-1:0];
      end else if (reg_addr_i == REG_VGA_GAIN) begin
        vga_shadow <= reg_data_i[VGA_GAIN_W-1:0];
      end else if (reg_addr_i == REG_CLAMP_DIV) begin
        clamp_div <= reg_data_i[7:0];
      end else if (reg_addr_i == REG_INT_CFG) begin
        internal_mode <= reg_data_i[INT_MODE_BIT];
      end
    end
  end

  // four pixel gain shadow registers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pgain
      always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
          pg_shadow[gi] <= PGAIN_RST;
        end else if (reg_wr_i && reg_addr_i == REG_PIX_GAIN0 + 8'(gi)) begin
          pg_shadow[gi] <= reg_data_i[PIX_GAIN_W-1:0];
        end
      end
    end
  endgenerate

  // horizontal sync delay to the h-counter reset edge
  logic       hs_dly_run;
  logic [2:0] hs_dly;
  logic       hcnt_rst;
  logic [11:0] hcnt;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hs_dly_run <= 1'b0;
      hs_dly     <= 3'h0;
      hcnt_rst   <= 1'b0;
    end else begin
      hcnt_rst <= 1'b0;
      if (hs_fall) begin
        hs_dly_run <= 1'b1;
        hs_dly     <= 3'h1;
      end else if (hs_dly_run) begin
        hs_dly <= hs_dly + 3'h1;
        if (hs_dly == HSYNC_DLY_LAST) begin
          hs_dly_run <= 1'b0;
          hcnt_rst   <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hcnt <= 12'h000;
    end else if (hcnt_rst) begin
      hcnt <= 12'h000;
    end else if (hcnt != 12'hfff) begin
      hcnt <= hcnt + 12'h001;
    end
  end

  // field parity, line pattern and settings transfer at sync boundaries
  logic       field_odd;
  logic       line_odd;
  logic [1:0] pix_phase;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      field_odd <= 1'b0;
      line_odd  <= 1'b0;
    end else if (vs_fall) begin
      field_odd <= ~field_odd;
      line_odd  <= 1'b0;
    end else if (hs_fall) begin
      line_odd  <= ~line_odd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      color_steer_select <= STEER_RST;
      vga_gain_o         <= VGA_RST;
      for (int i = 0; i < 4; i++) begin
        pg_live[i] <= PGAIN_RST;
      end
    end else if (vs_fall || hs_fall) begin
      color_steer_select <= steer_shadow;
      vga_gain_o         <= vga_shadow;
      for (int i = 0; i < 4; i++) begin
        pg_live[i] <= pg_shadow[i];
      end
    end
  end

  // pixel phase restarts at the h-counter reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pix_phase <= 2'h0;
    end else if (hcnt_rst) begin
      pix_phase <= 2'h0;
    end else if (color_steer_select == STEER_THREE && pix_phase == 2'h2) begin
      pix_phase <= 2'h0;
    end else begin
      pix_phase <= pix_phase + 2'h1;
    end
  end

  // gain index per pixel by steering mode
  logic [1:0] next_sel;
  always_comb begin
    next_sel = 2'h0;
    case (cgsc_steer_t'(color_steer_select))
      STEER_MOSAIC:    next_sel = {line_odd, pix_phase[0]};
      STEER_VSYNC_SEL: next_sel = {field_odd, pix_phase[0]};
      STEER_MOSAIC_IL: next_sel = {line_odd ^ field_odd, pix_phase[0]};
      STEER_THREE:     next_sel = pix_phase;
      STEER_FOUR_I:    next_sel = pix_phase;
      STEER_FOUR_II:   next_sel = {pix_phase[0], pix_phase[1]};
      STEER_FIXED:     next_sel = 2'h0;
      default:         next_sel = 2'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      gain_sel_o       <= 2'h0;
      pixel_gain_amp_o <= PGAIN_RST;
      steer_mode_o     <= STEER_RST;
      field_odd_o      <= 1'b0;
      vga_region_o     <= 1'b0;
    end else begin
      gain_sel_o       <= next_sel;
      pixel_gain_amp_o <= pg_live[next_sel];
      steer_mode_o     <= color_steer_select;
      field_odd_o      <= field_odd;
      vga_region_o     <= (vga_gain_o >= VGA_REGION_EDGE);
    end
  end

  // internal pulse generation from the h-counter
  function automatic logic in_win(input logic [11:0] pos, input logic [11:0] st, input logic [11:0] len);
    in_win = (pos >= st) && (pos < st + len);
  endfunction

  logic clp_act;
  assign clp_act = internal_mode ? in_win(hcnt, CLAMP_START, CLAMP_LEN) : clp_sync[1];

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      black_clamp_pulse_o <= 1'b0;
      dummy_clamp_pulse_o <= 1'b0;
      pre_blank_pulse_o   <= 1'b0;
      horiz_blank_pulse_o <= 1'b0;
    end else begin
      black_clamp_pulse_o <= clp_act;
      dummy_clamp_pulse_o <= internal_mode ? in_win(hcnt, DUMMY_START, DUMMY_LEN) : dm_sync[1];
      pre_blank_pulse_o   <= internal_mode ? in_win(hcnt, BLANK_START, BLANK_LEN) : pb_sync[1];
      horiz_blank_pulse_o <= internal_mode ? in_win(hcnt, BLANK_START, BLANK_LEN) : hb_sync[1];
    end
  end

  // clamp loop: integrate error during black interval, update per line or divided
  logic                 loop_off;
  logic [7:0]           line_cnt;
  logic                 upd_ok;
  logic signed [15:0]   err_acc;
  logic signed [15:0]   corr;
  logic signed [15:0]   ref_lvl;
  logic signed [15:0]   err;

  assign loop_off = operating_mode_reg[OPER_CLAMP_OFF_BIT];
  assign ref_lvl  = signed'({8'h00, clamp_level});
  assign err      = ref_lvl - signed'({4'h0, adc_data_i});
  assign upd_ok   = (line_cnt == 8'h00);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      line_cnt <= 8'h00;
    end else if (hcnt_rst) begin
      line_cnt <= upd_ok ? clamp_div : line_cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      err_acc <= 16'sh0000;
      corr    <= 16'sh0000;
    end else if (loop_off) begin
      err_acc <= 16'sh0000;
      corr    <= ref_lvl;
    end else if (hcnt_rst) begin
      if (upd_ok) begin
        corr <= corr + (err_acc >>> 4);
      end
      err_acc <= 16'sh0000;
    end else if (clp_act && upd_ok) begin
      err_acc <= err_acc + (err >>> 2);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      clamp_dac_o <= 10'h000;
    end else if (corr < 0) begin
      clamp_dac_o <= 10'h000;
    end else if (corr > 16'sh03ff) begin
      clamp_dac_o <= 10'h3ff;
    end else begin
      clamp_dac_o <= corr[CORR_W-1:0];
    end
  end

endmodule // cgsc_ctrl

// file: cgsc_ctrl_properties.sv
// checker for the ccd gain steering and clamp control block
// sees only the top ports; bound to every cgsc_ctrl instance
`timescale 1ns/100ps
module cgsc_ctrl_properties
  import cgsc_pkg::*;
(
  // clock, reset and register port
  input wire logic                  clk_i,
  input wire logic                  nrst_i,
  input wire logic                  reg_wr_i,
  input wire logic [7:0]            reg_addr_i,
  input wire logic [11:0]           reg_data_i,
  // pins
  input wire logic                  vertical_sync_i,
  input wire logic                  horizontal_sync_i,
  input wire logic                  black_clamp_pulse_i,
  // outputs
  input wire logic [1:0]            gain_sel_o,
  input wire logic [VGA_GAIN_W-1:0] vga_gain_o,
  input wire logic                  vga_region_o,
  input wire logic [CORR_W-1:0]     clamp_dac_o,
  input wire logic                  field_odd_o,
  input wire logic [STEER_W-1:0]    steer_mode_o,
  input wire logic                  black_clamp_pulse_o,
  input wire logic                  dummy_clamp_pulse_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic       vs_q, hs_q, off, intm;
  logic [7:0] lvl, q, sf, vf, cl, hf;
  // cycles since a sync fall and high run of the clamp output
  always_ff @(posedge clk_i) begin
    vs_q <= !nrst_i | vertical_sync_i;
    hs_q <= !nrst_i | horizontal_sync_i;
    cl   <= black_clamp_pulse_o ? cl + 8'h01 : 8'h00;
    vf   <= (vs_q && !vertical_sync_i) ? 8'h00 : vf + {7'h0, vf != 8'hff};
    hf   <= (hs_q && !horizontal_sync_i) ? 8'h00 : hf + {7'h0, hf != 8'hff};
    sf   <= ((vs_q && !vertical_sync_i) || (hs_q && !horizontal_sync_i)) ? 8'h00 : sf + {7'h0, sf != 8'hff};
  end
  // shadow of the written settings and cycles since the last write
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      off  <= 1'b0;
      intm <= 1'b0;
      lvl  <= CLAMP_RST;
      q    <= 8'h00;
    end else begin
      q <= reg_wr_i ? 8'h00 : q + {7'h0, q != 8'hff};
      if (reg_wr_i && reg_addr_i == REG_OPER_MODE)
        off <= reg_data_i[OPER_CLAMP_OFF_BIT];
      if (reg_wr_i && reg_addr_i == REG_CLAMP_LEVEL)
        lvl <= reg_data_i[7:0];
      if (reg_wr_i && reg_addr_i == REG_INT_CFG)
        intm <= reg_data_i[INT_MODE_BIT];
    end
  end
  property p_region; vga_region_o == $past(vga_gain_o[9]); endproperty
  a_region: assert property (p_region) else $error("vga region wrong");
  property p_steer_sync; $changed(steer_mode_o) |-> sf <= 8'h08; endproperty
  a_steer_sync: assert property (p_steer_sync) else $error("steer changed off sync");
  property p_vga_sync; $changed(vga_gain_o) |-> sf <= 8'h08; endproperty
  a_vga_sync: assert property (p_vga_sync) else $error("vga changed off sync");
  property p_field; $changed(field_odd_o) |-> vf <= 8'h08; endproperty
  a_field: assert property (p_field) else $error("field flipped off vsync");
  property p_fixed;
    steer_mode_o[2:1] == 2'b11 && $past(steer_mode_o) == steer_mode_o && $past(steer_mode_o, 2) == steer_mode_o
      |-> gain_sel_o == 2'h0;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed mode not gain 0");
  property p_clamp_fixed; off && q >= 8'h03 |-> clamp_dac_o == {2'h0, lvl}; endproperty
  a_clamp_fixed: assert property (p_clamp_fixed) else $error("clamp offset wrong");
  property p_pulse_pass; !intm && q >= 8'h04 |-> black_clamp_pulse_o == $past(black_clamp_pulse_i, 3); endproperty
  a_pulse_pass: assert property (p_pulse_pass) else $error("clamp pulse not passed");
  property p_int_clamp; intm && q >= 8'h64 && $fell(black_clamp_pulse_o) |-> cl == 8'h14; endproperty
  a_int_clamp: assert property (p_int_clamp) else $error("internal clamp width");
  property p_hcnt_align; intm && q >= 8'h64 && $rose(black_clamp_pulse_o) |-> hf == 8'h0a; endproperty
  a_hcnt_align: assert property (p_hcnt_align) else $error("clamp off h-counter reset");
  property p_int_dummy;
    intm && q >= 8'h64 && $rose(dummy_clamp_pulse_o) |-> dummy_clamp_pulse_o[*4] ##1 !dummy_clamp_pulse_o;
  endproperty
  a_int_dummy: assert property (p_int_dummy) else $error("internal dummy width");
endmodule // cgsc_ctrl_properties
bind cgsc_ctrl cgsc_ctrl_properties u_props (.*);

// file: cgsc_sync_src.sv
// model of the image asic: line and field syncs, clamp pulse, converter data
// runs on the master clock, changes on the falling edge; syncs idle high
`timescale 1ns/100ps
module cgsc_sync_src #(
  parameter int LINE_LEN    = 80,
  parameter int FIELD_LINES = 4
) (
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic [11:0] adc_lvl_i,
  output logic             vsync_o,
  output logic             hsync_o,
  output logic             clamp_o,
  output logic [11:0]      adc_o
);
  int h = 0;
  int ln = 0;
  always @(negedge clk_i) begin
    if (!run_i || h == LINE_LEN - 1) begin
      h  <= 0;
      ln <= (!run_i || ln == FIELD_LINES - 1) ? 0 : ln + 1;
    end else begin
      h <= h + 1;
    end
  end
  // vsync falls mid-line so it never meets an hsync fall
  assign hsync_o = !(run_i && h < 4);
  assign vsync_o = !(run_i && ln == 0 && h >= 40 && h < 44);
  assign clamp_o = run_i && h >= 8 && h < 32;
  assign adc_o   = adc_lvl_i;
endmodule // cgsc_sync_src

// file: tb_cgsc_ctrl.sv
// bench for the ccd gain steering and clamp control block
// inputs change on the falling clock edge; syncs come from cgsc_sync_src
`timescale 1ns/100ps
module tb_cgsc_ctrl
  import cgsc_pkg::*;
;
  logic                  clk_i      = 1'b0;
  logic                  nrst_i     = 1'b0;
  logic                  reg_wr_i   = 1'b0;
  logic [7:0]            reg_addr_i = 8'h00;
  logic [11:0]           reg_data_i = 12'h000;
  logic                  run        = 1'b0;
  logic [11:0]           adc_lvl    = 12'h000;
  logic                  vs, hs, clp, vreg, fodd, bcp, dcp, pbp, hbp;
  logic [11:0]           adc;
  logic [PIX_GAIN_W-1:0] pga;
  logic [1:0]            gsel;
  logic [VGA_GAIN_W-1:0] vga;
  logic [CORR_W-1:0]     dac;
  logic [STEER_W-1:0]    smode;
  logic [5:0]            pg [4] = '{6'h05, 6'h09, 6'h11, 6'h3f};
  logic [9:0]            vv [4] = '{10'h1ff, 10'h200, 10'h3ff, 10'h000};
  int                    n_errors = 0;
  int                    compares = 0;
  int                    cyc = 0;
  always #4 clk_i = ~clk_i;
  cgsc_sync_src src (.clk_i(clk_i), .run_i(run), .adc_lvl_i(adc_lvl), .vsync_o(vs), .hsync_o(hs), .clamp_o(clp),
                     .adc_o(adc));
  cgsc_ctrl dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_data_i(reg_data_i), .vertical_sync_i(vs), .horizontal_sync_i(hs), .black_clamp_pulse_i(clp),
    .dummy_clamp_pulse_i(clp), .pre_blank_pulse_i(clp), .horiz_blank_pulse_i(clp), .adc_data_i(adc),
    .pixel_gain_amp_o(pga), .gain_sel_o(gsel), .vga_gain_o(vga), .vga_region_o(vreg), .clamp_dac_o(dac),
    .field_odd_o(fodd), .steer_mode_o(smode), .black_clamp_pulse_o(bcp), .dummy_clamp_pulse_o(dcp),
    .pre_blank_pulse_o(pbp), .horiz_blank_pulse_o(hbp));
  task automatic results();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [11:0] exp, logic [11:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [11:0] d);
    reg_addr_i = a;
    reg_data_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask
  // wait for a vsync (v) or hsync fall, then well into the line
  task automatic sync(bit v);
    if (v) @(negedge vs);
    else @(negedge hs);
    repeat (30) @(negedge clk_i);
  endtask
  task automatic count_line(output int nb, output int nd, output int np);
    nb = 0;
    nd = 0;
    np = 0;
    repeat (80) begin
      @(negedge clk_i);
      nb += int'(bcp);
      nd += int'(dcp);
      np += int'(pbp && hbp);
    end
  endtask
  task automatic t_mosaic();
    logic [1:0] g;
    for (int i = 0; i < 4; i++) wr(REG_PIX_GAIN0 + 8'(i), 12'(pg[i]));
    wr(REG_STEER_SEL, 12'(STEER_MOSAIC));
    sync(1);
    for (int l = 0; l < 3; l++) begin
      g = gsel;
      chk("line", 12'(l % 2), 12'(g[1]));
      chk("gain", 12'(pg[g]), 12'(pga));
      @(negedge clk_i);
      chk("pixel", 12'({g[1], ~g[0]}), 12'(gsel));
      sync(0);
    end
  endtask
  task automatic t_vsel();
    logic o;
    wr(REG_STEER_SEL, 12'(STEER_VSYNC_SEL));
    for (int f = 0; f < 2; f++) begin
      o = fodd;
      sync(1);
      chk("field", 12'(!o), 12'(fodd));
      chk("fsel", 12'(fodd), 12'(gsel[1]));
      sync(0);
      chk("fsel2", 12'(fodd), 12'(gsel[1]));
    end
  endtask
  task automatic t_modes();
    logic [1:0] g, e, pn;
    for (int m = 2; m < 8; m++) begin
      wr(REG_STEER_SEL, 12'(m));
      wr(8'h3f, 12'h000);
      chk("hold", 12'(m - 1), 12'(smode));
      sync(0);
      chk("mode", 12'(m), 12'(smode));
      if (m > 5) chk("fixed", 12'h000, 12'(gsel));
      g = gsel;
      @(negedge clk_i);
      pn = {g[0], g[1]} + 2'h1;
      if (m == 2) e = {g[1], ~g[0]};
      else if (m == 3) e = (g == 2'h2) ? 2'h0 : g + 2'h1;
      else if (m == 4) e = g + 2'h1;
      else if (m == 5) e = {pn[0], pn[1]};
      else e = 2'h0;
      chk("seq", 12'(e), 12'(gsel));
    end
  endtask
  task automatic t_vga();
    for (int i = 0; i < 4; i++) begin
      wr(REG_VGA_GAIN, 12'(vv[i]));
      sync(0);
      chk("vga", 12'(vv[i]), 12'(vga));
      chk("region", 12'(vv[i] > 10'h1ff), 12'(vreg));
    end
  endtask
  task automatic t_clamp();
    logic [CORR_W-1:0] d;
    int n;
    wr(REG_OPER_MODE, 12'h004);
    wr(REG_CLAMP_LEVEL, 12'h0ff);
    repeat (3) @(negedge clk_i);
    chk("offset", 12'h0ff, 12'(dac));
    wr(REG_CLAMP_LEVEL, 12'h080);
    wr(REG_OPER_MODE, 12'h000);
    sync(0);
    d = dac;
    sync(0);
    chk("up", 12'h001, 12'(dac > d));
    adc_lvl = 12'h300;
    sync(0);
    d = dac;
    sync(0);
    chk("down", 12'h001, 12'(dac < d));
    adc_lvl = 12'h000;
    wr(REG_OPER_MODE, 12'h004);
    wr(REG_OPER_MODE, 12'h000);
    wr(REG_CLAMP_DIV, 12'h003);
    n = 0;
    for (int l = 0; l < 8; l++) begin
      d = dac;
      sync(0);
      n += int'(dac != d);
    end
    chk("slow", 12'h001, 12'(n >= 1 && n <= 3));
  endtask
  task automatic t_int();
    int nb, nd, np;
    wr(REG_INT_CFG, 12'h001);
    sync(0);
    sync(0);
    count_line(nb, nd, np);
    chk("int_clamp", 12'h014, 12'(nb));
    chk("int_dummy", 12'h004, 12'(nd));
    chk("int_blank", 12'h040, 12'(np));
    wr(REG_INT_CFG, 12'h000);
    sync(0);
    count_line(nb, nd, np);
    chk("ext_clamp", 12'h018, 12'(nb));
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    chk("steer_rst", 12'(STEER_RST), 12'(smode));
    run = 1'b1;
    t_mosaic();
    t_vsel();
    t_modes();
    t_vga();
    t_clamp();
    t_int();
    results();
  end
endmodule // tb_cgsc_ctrl
